// ### rtl/ivmu_regs.svh
`ifndef IVMU_REGS_SVH
`define IVMU_REGS_SVH

// first vector number handled by this block, and how many slots follow it
`define IVMU_VEC_BASE 8'h28
`define IVMU_NUM_SRC 48
`define IVMU_IDX_W 6

// priority level field positions inside each 8-bit group
`define IVMU_HI_MSB 6
`define IVMU_HI_LSB 4
`define IVMU_LO_MSB 2
`define IVMU_LO_LSB 0

// slot index (vector minus base) where each priority field takes over
`define IVMU_IDX_G_HI 6'h04
`define IVMU_IDX_G_LO 6'h08
`define IVMU_IDX_H_HI 6'h10
`define IVMU_IDX_H_LO 6'h14
`define IVMU_IDX_I_HI 6'h18
`define IVMU_IDX_I_LO 6'h1c
`define IVMU_IDX_J_LO 6'h28
`define IVMU_IDX_K_HI 6'h2c

// reset value of the vector, address and level output registers
`define IVMU_RST_VEC 8'h00
`define IVMU_RST_ADDR 16'h0000
`define IVMU_RST_LVL 3'h0

`endif

// ### rtl/ivmu_pkg.sv
`default_nettype none

package ivmu_pkg;

  typedef logic [2:0] ivmu_level_type;

  // which priority field feeds a slot
  typedef enum logic [3:0] {
    IVMU_FLD_F_LO = 4'h0,
    IVMU_FLD_G_HI = 4'h1,
    IVMU_FLD_G_LO = 4'h2,
    IVMU_FLD_H_HI = 4'h3,
    IVMU_FLD_H_LO = 4'h4,
    IVMU_FLD_I_HI = 4'h5,
    IVMU_FLD_I_LO = 4'h6,
    IVMU_FLD_J_LO = 4'h7,
    IVMU_FLD_K_HI = 4'h8
  } ivmu_field_type;

  // presentation state toward the exception sequencer
  typedef enum logic [0:0] {
    IVMU_ST_IDLE = 1'b0,
    IVMU_ST_PRESENT = 1'b1
  } ivmu_state_type;

endpackage

`default_nettype wire

// ### rtl/ivmu_source_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivmu_regs.svh"

module ivmu_source_map (
  input wire logic [7:0] prio_group_f_in,
  input wire logic [7:0] prio_group_g_in,
  input wire logic [7:0] prio_group_h_in,
  input wire logic [7:0] prio_group_i_in,
  input wire logic [7:0] prio_group_j_in,
  input wire logic [7:0] prio_group_k_in,
  output logic [3*`IVMU_NUM_SRC-1:0] levels_out
);

  // slot index to priority field; slots share a field per peripheral channel
  function automatic ivmu_pkg::ivmu_field_type field_of(input logic [`IVMU_IDX_W-1:0] idx);
    if (idx < `IVMU_IDX_G_HI) field_of = ivmu_pkg::IVMU_FLD_F_LO;
    else if (idx < `IVMU_IDX_G_LO) field_of = ivmu_pkg::IVMU_FLD_G_HI;
    else if (idx < `IVMU_IDX_H_HI) field_of = ivmu_pkg::IVMU_FLD_G_LO;
    else if (idx < `IVMU_IDX_H_LO) field_of = ivmu_pkg::IVMU_FLD_H_HI;
    else if (idx < `IVMU_IDX_I_HI) field_of = ivmu_pkg::IVMU_FLD_H_LO;
    else if (idx < `IVMU_IDX_I_LO) field_of = ivmu_pkg::IVMU_FLD_I_HI;
    else if (idx < `IVMU_IDX_J_LO) field_of = ivmu_pkg::IVMU_FLD_I_LO;
    else if (idx < `IVMU_IDX_K_HI) field_of = ivmu_pkg::IVMU_FLD_J_LO;
    else field_of = ivmu_pkg::IVMU_FLD_K_HI;
  endfunction

  // one level lookup per slot
  genvar gi;
  generate
    for (gi = 0; gi < `IVMU_NUM_SRC; gi = gi + 1) begin : g_slot
      always_comb begin
        case (field_of(`IVMU_IDX_W'(gi)))
          ivmu_pkg::IVMU_FLD_F_LO: levels_out[3*gi +: 3] = prio_group_f_in[`IVMU_LO_MSB:`IVMU_LO_LSB];
          ivmu_pkg::IVMU_FLD_G_HI: levels_out[3*gi +: 3] = prio_group_g_in[`IVMU_HI_MSB:`IVMU_HI_LSB];
          ivmu_pkg::IVMU_FLD_G_LO: levels_out[3*gi +: 3] = prio_group_g_in[`IVMU_LO_MSB:`IVMU_LO_LSB];
          ivmu_pkg::IVMU_FLD_H_HI: levels_out[3*gi +: 3] = prio_group_h_in[`IVMU_HI_MSB:`IVMU_HI_LSB];
          ivmu_pkg::IVMU_FLD_H_LO: levels_out[3*gi +: 3] = prio_group_h_in[`IVMU_LO_MSB:`IVMU_LO_LSB];
          ivmu_pkg::IVMU_FLD_I_HI: levels_out[3*gi +: 3] = prio_group_i_in[`IVMU_HI_MSB:`IVMU_HI_LSB];
          ivmu_pkg::IVMU_FLD_I_LO: levels_out[3*gi +: 3] = prio_group_i_in[`IVMU_LO_MSB:`IVMU_LO_LSB];
          ivmu_pkg::IVMU_FLD_J_LO: levels_out[3*gi +: 3] = prio_group_j_in[`IVMU_LO_MSB:`IVMU_LO_LSB];
          default: levels_out[3*gi +: 3] = prio_group_k_in[`IVMU_HI_MSB:`IVMU_HI_LSB];
        endcase
      end
    end
  endgenerate

endmodule // ivmu_source_map

`default_nettype wire

// ### rtl/ivmu_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivmu_regs.svh"

module ivmu_arbiter (
  input wire logic [`IVMU_NUM_SRC-1:0] req_in,
  input wire logic [3*`IVMU_NUM_SRC-1:0] levels_in,
  input wire logic mode2_in,
  input wire logic mask_bit_in,
  input wire logic [2:0] mask_level_in,
  output logic found_out,
  output logic [`IVMU_IDX_W-1:0] idx_out,
  output logic [2:0] level_out
);

  // two passes: best level among eligible slots, then lowest slot at that level.
  // in mode 0 levels are ignored, so every eligible slot counts as level 0.
  always_comb begin
    logic [`IVMU_NUM_SRC-1:0] elig;
    logic [2:0] best;
    elig = '0;
    best = 3'h0;
    found_out = 1'b0;
    idx_out = '0;
    level_out = 3'h0;
    for (int i = 0; i < `IVMU_NUM_SRC; i++) begin
      elig[i] = req_in[i] && (mode2_in ? (levels_in[3*i +: 3] > mask_level_in) : !mask_bit_in);
      if (elig[i] && mode2_in && levels_in[3*i +: 3] > best) best = levels_in[3*i +: 3];
    end
    // descending scan so the lowest vector number is the last written
    for (int i = `IVMU_NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i] && (!mode2_in || levels_in[3*i +: 3] == best)) begin
        found_out = 1'b1;
        idx_out = i[`IVMU_IDX_W-1:0];
        level_out = mode2_in ? best : 3'h0;
      end
    end
  end

endmodule // ivmu_arbiter

`default_nettype wire

// ### rtl/ivmu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivmu_regs.svh"


module ivmu_top (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // address mode and acceptance control from the cpu, plus the acknowledge from the exception sequencer
  input wire logic advanced_mode_in,
  input wire logic mode2_in,
  input wire logic mask_bit_in,
  input wire logic [2:0] mask_level_in,
  input wire logic ack_in,
  // priority level fields
  input wire logic [7:0] prio_group_f_in,
  input wire logic [7:0] prio_group_g_in,
  input wire logic [7:0] prio_group_h_in,
  input wire logic [7:0] prio_group_i_in,
  input wire logic [7:0] prio_group_j_in,
  input wire logic [7:0] prio_group_k_in,
  // multifunction timer requests
  input wire logic mt1_match_a_irq_in,
  input wire logic mt1_match_b_irq_in,
  input wire logic mt1_overflow_irq_in,
  input wire logic mt1_underflow_irq_in,
  input wire logic [3:0] mt2_irq_in,
  input wire logic [4:0] mt3_irq_in,
  input wire logic [3:0] mt4_irq_in,
  input wire logic [3:0] mt5_irq_in,
  // 8-bit timer requests
  input wire logic t8_0_match_a_irq_in,
  input wire logic t8_0_match_b_irq_in,
  input wire logic t8_0_overflow_irq_in,
  input wire logic t8_1_match_a_irq_in,
  input wire logic t8_1_match_b_irq_in,
  input wire logic t8_1_overflow_irq_in,
  // serial requests
  input wire logic ser0_rx_error_irq_in,
  input wire logic ser0_rx_done_irq_in,
  input wire logic ser0_tx_empty_irq_in,
  input wire logic ser0_tx_end_irq_in,
  input wire logic ser1_rx_error_irq_in,
  input wire logic ser1_rx_done_irq_in,
  input wire logic ser1_tx_empty_irq_in,
  input wire logic ser1_tx_end_irq_in,
  // toward the exception sequencer
  output logic irq_req_out,
  output logic [7:0] vector_out,
  output logic [15:0] vector_addr_out,
  output logic [2:0] level_out
);

  // table address from vector number: two bytes a slot normally, four in advanced mode
  function automatic logic [15:0] table_addr(input logic [7:0] vec, input logic adv);
    table_addr = adv ? {6'h00, vec, 2'b00} : {7'h00, vec, 1'b0};
  endfunction

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_reg;
  logic rst_n_sync_reg;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync_reg <= rst_meta_reg;
    end
  end

  // slot vector, bit n is vector base+n; reserved slots are tied low so they never win
  logic [`IVMU_NUM_SRC-1:0] src_req;
  assign src_req[3:0] = {mt1_underflow_irq_in, mt1_overflow_irq_in,
                         mt1_match_b_irq_in, mt1_match_a_irq_in};
  assign src_req[7:4] = mt2_irq_in;
  assign src_req[15:8] = {3'b000, mt3_irq_in};
  assign src_req[19:16] = mt4_irq_in;
  assign src_req[23:20] = mt5_irq_in;
  assign src_req[27:24] = {1'b0, t8_0_overflow_irq_in,
                           t8_0_match_b_irq_in, t8_0_match_a_irq_in};
  assign src_req[39:28] = {9'h000, t8_1_overflow_irq_in,
                           t8_1_match_b_irq_in, t8_1_match_a_irq_in};
  assign src_req[43:40] = {ser0_tx_end_irq_in, ser0_tx_empty_irq_in,
                           ser0_rx_done_irq_in, ser0_rx_error_irq_in};
  assign src_req[47:44] = {ser1_tx_end_irq_in, ser1_tx_empty_irq_in,
                           ser1_rx_done_irq_in, ser1_rx_error_irq_in};

  logic [3*`IVMU_NUM_SRC-1:0] slot_levels;
  logic win_found;
  logic [`IVMU_IDX_W-1:0] win_idx;
  logic [2:0] win_level;

  ivmu_source_map u_map (
    .prio_group_f_in(prio_group_f_in),
    .prio_group_g_in(prio_group_g_in),
    .prio_group_h_in(prio_group_h_in),
    .prio_group_i_in(prio_group_i_in),
    .prio_group_j_in(prio_group_j_in),
    .prio_group_k_in(prio_group_k_in),
    .levels_out(slot_levels)
  );

  ivmu_arbiter u_arb (
    .req_in(src_req),
    .levels_in(slot_levels),
    .mode2_in(mode2_in),
    .mask_bit_in(mask_bit_in),
    .mask_level_in(mask_level_in),
    .found_out(win_found),
    .idx_out(win_idx),
    .level_out(win_level)
  );

  logic [7:0] win_vec;
  assign win_vec = `IVMU_VEC_BASE + {2'b00, win_idx};

  ivmu_pkg::ivmu_state_type state_reg;
  ivmu_pkg::ivmu_state_type state_next;
  logic [7:0] vec_reg;
  logic [7:0] vec_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [2:0] lvl_reg;
  logic [2:0] lvl_next;

  // the winner is refreshed every cycle until the sequencer acknowledges, so a
  // newer higher-ranked source can still displace it. after an ack the request
  // drops for one cycle, giving the peripheral time to clear its flag.
  always_comb begin
    state_next = state_reg;
    vec_next = vec_reg;
    addr_next = addr_reg;
    lvl_next = lvl_reg;
    case (state_reg)
      ivmu_pkg::IVMU_ST_IDLE: begin
        if (win_found) begin
          state_next = ivmu_pkg::IVMU_ST_PRESENT;
          vec_next = win_vec;
          addr_next = table_addr(win_vec, advanced_mode_in);
          lvl_next = win_level;
        end
      end
      ivmu_pkg::IVMU_ST_PRESENT: begin
        if (ack_in || !win_found) begin
          state_next = ivmu_pkg::IVMU_ST_IDLE;
        end else begin
          vec_next = win_vec;
          addr_next = table_addr(win_vec, advanced_mode_in);
          lvl_next = win_level;
        end
      end
      default: begin
        state_next = ivmu_pkg::IVMU_ST_IDLE;
      end
    endcase
  end

  // output registers
  always_ff @(posedge ref_clk_in or negedge rst_n_sync_reg) begin
    if (!rst_n_sync_reg) begin
      state_reg <= ivmu_pkg::IVMU_ST_IDLE;
      vec_reg <= `IVMU_RST_VEC;
      addr_reg <= `IVMU_RST_ADDR;
      lvl_reg <= `IVMU_RST_LVL;
    end else begin
      state_reg <= state_next;
      vec_reg <= vec_next;
      addr_reg <= addr_next;
      lvl_reg <= lvl_next;
    end
  end

  assign irq_req_out = (state_reg == ivmu_pkg::IVMU_ST_PRESENT);
  assign vector_out = vec_reg;
  assign vector_addr_out = addr_reg;
  assign level_out = lvl_reg;

  // checks: a lone eligible source seen while idle must be presented next cycle
  sequence s_lone_pick(int bitpos);
    (state_reg == ivmu_pkg::IVMU_ST_IDLE) && win_found && (src_req == (48'h1 << bitpos));
  endsequence

  sequence s_presented(logic [7:0] vec, logic [2:0] lvl);
    irq_req_out && (vector_out == vec) && (level_out == lvl);
  endsequence

  a_addr_format: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    $rose(irq_req_out) |-> vector_addr_out ==
      ($past(advanced_mode_in) ? {6'h00, vector_out, 2'b00} : {7'h00, vector_out, 1'b0}))
    else $error("vector address does not match vector number and mode");

  a_mt1_match_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(0) |=> s_presented(8'h28, ($past(mode2_in) ? $past(prio_group_f_in[2:0]) : 3'h0)))
    else $error("timer 1 match a not presented as vector 40");

  a_t8_0_match_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(24) |=> s_presented(8'h40, ($past(mode2_in) ? $past(prio_group_i_in[6:4]) : 3'h0)))
    else $error("8-bit timer 0 match a not presented as vector 64");

  a_ser0_rx_err: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(40) |=> s_presented(8'h50, ($past(mode2_in) ? $past(prio_group_j_in[2:0]) : 3'h0)))
    else $error("serial 0 receive error not presented as vector 80");

  a_ser1_tx_end: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(47) |=> s_presented(8'h57, ($past(mode2_in) ? $past(prio_group_k_in[6:4]) : 3'h0)))
    else $error("serial 1 transmit end not presented as vector 87");

  // remaining timer 1, 8-bit timer and serial sources plus one of each of timers 2 to 5, one lone pick each, so every level field is checked
  a_mt1_match_b: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(1) |=> s_presented(8'h29, ($past(mode2_in) ? $past(prio_group_f_in[2:0]) : 3'h0)))
    else $error("timer 1 match b not presented as vector 41");

  a_mt1_overflow: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(2) |=> s_presented(8'h2a, ($past(mode2_in) ? $past(prio_group_f_in[2:0]) : 3'h0)))
    else $error("timer 1 overflow not presented as vector 42");

  a_mt1_underflow: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(3) |=> s_presented(8'h2b, ($past(mode2_in) ? $past(prio_group_f_in[2:0]) : 3'h0)))
    else $error("timer 1 underflow not presented as vector 43");

  a_mt2_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(4) |=> s_presented(8'h2c, ($past(mode2_in) ? $past(prio_group_g_in[6:4]) : 3'h0)))
    else $error("timer 2 first source not presented as vector 44");

  a_mt3_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(8) |=> s_presented(8'h30, ($past(mode2_in) ? $past(prio_group_g_in[2:0]) : 3'h0)))
    else $error("timer 3 first source not presented as vector 48");

  a_mt4_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(16) |=> s_presented(8'h38, ($past(mode2_in) ? $past(prio_group_h_in[6:4]) : 3'h0)))
    else $error("timer 4 first source not presented as vector 56");

  a_mt5_last: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(23) |=> s_presented(8'h3f, ($past(mode2_in) ? $past(prio_group_h_in[2:0]) : 3'h0)))
    else $error("timer 5 last source not presented as vector 63");

  a_t8_0_match_b: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(25) |=> s_presented(8'h41, ($past(mode2_in) ? $past(prio_group_i_in[6:4]) : 3'h0)))
    else $error("8-bit timer 0 match b not presented as vector 65");

  a_t8_0_overflow: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(26) |=> s_presented(8'h42, ($past(mode2_in) ? $past(prio_group_i_in[6:4]) : 3'h0)))
    else $error("8-bit timer 0 overflow not presented as vector 66");

  a_t8_1_match_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(28) |=> s_presented(8'h44, ($past(mode2_in) ? $past(prio_group_i_in[2:0]) : 3'h0)))
    else $error("8-bit timer 1 match a not presented as vector 68");

  a_t8_1_match_b: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(29) |=> s_presented(8'h45, ($past(mode2_in) ? $past(prio_group_i_in[2:0]) : 3'h0)))
    else $error("8-bit timer 1 match b not presented as vector 69");

  a_t8_1_overflow: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(30) |=> s_presented(8'h46, ($past(mode2_in) ? $past(prio_group_i_in[2:0]) : 3'h0)))
    else $error("8-bit timer 1 overflow not presented as vector 70");

  a_ser0_rx_done: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(41) |=> s_presented(8'h51, ($past(mode2_in) ? $past(prio_group_j_in[2:0]) : 3'h0)))
    else $error("serial 0 receive done not presented as vector 81");

  a_ser0_tx_empty: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(42) |=> s_presented(8'h52, ($past(mode2_in) ? $past(prio_group_j_in[2:0]) : 3'h0)))
    else $error("serial 0 transmit empty not presented as vector 82");

  a_ser0_tx_end: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(43) |=> s_presented(8'h53, ($past(mode2_in) ? $past(prio_group_j_in[2:0]) : 3'h0)))
    else $error("serial 0 transmit end not presented as vector 83");

  a_ser1_rx_err: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(44) |=> s_presented(8'h54, ($past(mode2_in) ? $past(prio_group_k_in[6:4]) : 3'h0)))
    else $error("serial 1 receive error not presented as vector 84");

  a_ser1_rx_done: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(45) |=> s_presented(8'h55, ($past(mode2_in) ? $past(prio_group_k_in[6:4]) : 3'h0)))
    else $error("serial 1 receive done not presented as vector 85");

  a_ser1_tx_empty: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    s_lone_pick(46) |=> s_presented(8'h56, ($past(mode2_in) ? $past(prio_group_k_in[6:4]) : 3'h0)))
    else $error("serial 1 transmit empty not presented as vector 86");

  // a standing request follows the current winner until the ack lands
  a_winner_refresh: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    irq_req_out && !ack_in && win_found |=> irq_req_out && (vector_out == $past(win_vec)))
    else $error("standing request not refreshed to the current winner");

  a_vec_not_reserved: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    irq_req_out |-> (vector_out >= 8'h28) && (vector_out <= 8'h57) && !(vector_out inside {[8'h35:8'h37], 8'h43, [8'h47:8'h4f]}))
    else $error("reserved or out-of-range vector presented");

  a_tie_low_vector: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    ((state_reg == ivmu_pkg::IVMU_ST_IDLE) && !mode2_in && !mask_bit_in && src_req[0] && src_req[47])
      |=> s_presented(8'h28, 3'h0))
    else $error("equal-level tie not resolved to lowest vector");

  a_level_over_mask: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    (irq_req_out && $past(mode2_in) && $past(irq_req_out || win_found)) |-> level_out > $past(mask_level_in))
    else $error("presented level not above mask level");

  a_ack_release: assert property (@(posedge ref_clk_in) disable iff (!rst_n_sync_reg)
    irq_req_out && ack_in |=> !irq_req_out ##1 (irq_req_out == $past(win_found)))
    else $error("request not withdrawn for one cycle after acknowledge");

endmodule // ivmu_top

`default_nettype wire

// ### verification/ivmu_seq_model.sv
`timescale 1ns/1ps
`default_nettype none

// stand-in for the exception sequencer: acks a standing request delay_in+1 cycles after it rises
module ivmu_seq_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic irq_req_in,
  input wire logic [3:0] delay_in,
  output logic ack_out
);
  logic [3:0] wait_reg;

  // one ack pulse per presentation; the count restarts once the request falls,
  // so a request that stays low for its gap cycle is never acked twice
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_reg <= 4'h0;
      ack_out <= 1'b0;
    end else if (ack_out || !irq_req_in) begin
      wait_reg <= 4'h0;
      ack_out <= 1'b0;
    end else if (wait_reg == delay_in) begin
      ack_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // ivmu_seq_model

`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic ref_clk_in;
  logic reset_n_in;
  logic advanced_mode_in;
  logic mode2_in;
  logic mask_bit_in;
  logic [2:0] mask_level_in;
  logic ack_in;
  logic irq_req_out;
  logic [7:0] vector_out;
  logic [15:0] vector_addr_out;
  logic [2:0] level_out;
  logic [7:0] grp_r [6];
  logic [47:0] req_r;
  logic [3:0] delay_r;
  int miscompares;
  int n_tests;
  int cycles;
  // level field table: group index, high field flag, first vector fed by it
  int fld_grp [9] = '{0, 1, 1, 2, 2, 3, 3, 4, 5};
  int fld_hi [9] = '{0, 1, 0, 1, 0, 1, 0, 0, 1};
  int fld_vec [9] = '{40, 44, 48, 56, 60, 64, 68, 80, 84};

  ivmu_top i_dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .advanced_mode_in(advanced_mode_in),
    .mode2_in(mode2_in), .mask_bit_in(mask_bit_in), .mask_level_in(mask_level_in), .ack_in(ack_in),
    .prio_group_f_in(grp_r[0]), .prio_group_g_in(grp_r[1]), .prio_group_h_in(grp_r[2]),
    .prio_group_i_in(grp_r[3]), .prio_group_j_in(grp_r[4]), .prio_group_k_in(grp_r[5]),
    .mt1_match_a_irq_in(req_r[0]), .mt1_match_b_irq_in(req_r[1]), .mt1_overflow_irq_in(req_r[2]),
    .mt1_underflow_irq_in(req_r[3]), .mt2_irq_in(req_r[7:4]), .mt3_irq_in(req_r[12:8]),
    .mt4_irq_in(req_r[19:16]), .mt5_irq_in(req_r[23:20]),
    .t8_0_match_a_irq_in(req_r[24]), .t8_0_match_b_irq_in(req_r[25]), .t8_0_overflow_irq_in(req_r[26]),
    .t8_1_match_a_irq_in(req_r[28]), .t8_1_match_b_irq_in(req_r[29]), .t8_1_overflow_irq_in(req_r[30]),
    .ser0_rx_error_irq_in(req_r[40]), .ser0_rx_done_irq_in(req_r[41]), .ser0_tx_empty_irq_in(req_r[42]),
    .ser0_tx_end_irq_in(req_r[43]), .ser1_rx_error_irq_in(req_r[44]), .ser1_rx_done_irq_in(req_r[45]),
    .ser1_tx_empty_irq_in(req_r[46]), .ser1_tx_end_irq_in(req_r[47]),
    .irq_req_out(irq_req_out), .vector_out(vector_out), .vector_addr_out(vector_addr_out),
    .level_out(level_out)
  );

  ivmu_seq_model i_seq (
    .clk_in(ref_clk_in), .reset_n_in(reset_n_in), .irq_req_in(irq_req_out), .delay_in(delay_r),
    .ack_out(ack_in)
  );

  // free-running clock, 100 ns period
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // hang guard: far above the less than a thousand cycles the scenarios need
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // slots with no source behind them
  function automatic bit usable(int i);
    return !((i >= 13 && i <= 15) || i == 27 || (i >= 31 && i <= 39));
  endfunction

  task automatic set_all();
    for (int i = 0; i < 48; i++) begin
      req_r[i] = usable(i);
    end
  endtask

  // wait for a presentation, judge it, let the sequencer ack, then drop the flag
  task automatic present(input int vec, input logic [2:0] lvl);
    int n;
    logic [15:0] addr;
    n = 0;
    addr = advanced_mode_in ? 16'(vec * 4) : 16'(vec * 2);
    while (irq_req_out !== 1'b1 && n < 20) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("request", {15'h0000, irq_req_out}, 16'h0001);
    check("vector", {8'h00, vector_out}, 16'(vec));
    check("address", vector_addr_out, addr);
    check("level", {13'h0000, level_out}, {13'h0000, lvl});
    n = 0;
    while (ack_in !== 1'b1 && n < 20) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("vector held", {8'h00, vector_out}, 16'(vec));
    req_r[vec - 40] = 1'b0;
    @(negedge ref_clk_in);
    check("gap after ack", {15'h0000, irq_req_out}, 16'h0000);
  endtask

  // no presentation may appear for eight cycles
  task automatic no_irq();
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(negedge ref_clk_in);
      seen = seen | irq_req_out;
    end
    check("masked request", {15'h0000, seen}, 16'h0000);
  endtask

  task automatic quiet();
    req_r = 48'h000000000000;
    repeat (4) @(negedge ref_clk_in);
  endtask

  // every source alone, in both address modes
  task automatic t_all_vectors();
    for (int m = 0; m < 2; m++) begin
      advanced_mode_in = m[0];
      for (int v = 40; v < 88; v++) begin
        if (usable(v - 40)) begin
          req_r[v - 40] = 1'b1;
          present(v, 3'h0);
          check("idle", {15'h0000, irq_req_out}, 16'h0000);
        end
      end
    end
    advanced_mode_in = 1'b0;
  endtask

  // all sources at once with a slow sequencer: mode 0, then mode 2 at equal levels
  task automatic t_order();
    delay_r = 4'h5;
    for (int m = 0; m < 2; m++) begin
      mode2_in = m[0];
      for (int g = 0; g < 6; g++) begin
        grp_r[g] = 8'h33;
      end
      set_all();
      for (int v = 40; v < 88; v++) begin
        if (usable(v - 40)) begin
          present(v, m[0] ? 3'h3 : 3'h0);
        end
      end
    end
    delay_r = 4'h0;
  endtask

  // one field raised above the rest decides the winner
  task automatic t_fields();
    mode2_in = 1'b1;
    mask_level_in = 3'h0;
    for (int k = 0; k < 9; k++) begin
      for (int g = 0; g < 6; g++) begin
        grp_r[g] = 8'h11;
      end
      if (fld_hi[k] == 1) begin
        grp_r[fld_grp[k]][6:4] = 3'h5;
      end else begin
        grp_r[fld_grp[k]][2:0] = 3'h5;
      end
      set_all();
      present(fld_vec[k], 3'h5);
      quiet();
    end
  endtask

  // acceptance: mask bit in mode 0, mask level in mode 2
  task automatic t_mask();
    for (int g = 0; g < 6; g++) begin
      grp_r[g] = 8'h55;
    end
    mode2_in = 1'b0;
    mask_bit_in = 1'b1;
    req_r[44] = 1'b1;
    no_irq();
    mask_bit_in = 1'b0;
    present(84, 3'h0);
    mode2_in = 1'b1;
    mask_bit_in = 1'b1;
    mask_level_in = 3'h5;
    req_r[44] = 1'b1;
    no_irq();
    mask_level_in = 3'h4;
    present(84, 3'h5);
    quiet();
  endtask

  // a higher-ranked source arriving while a request stands takes over before the ack
  task automatic t_newcomer();
    mode2_in = 1'b0;
    mask_bit_in = 1'b0;
    delay_r = 4'h5;
    req_r[47] = 1'b1;
    @(negedge ref_clk_in);
    check("first winner", {8'h00, vector_out}, 16'h0057);
    req_r[0] = 1'b1;
    @(negedge ref_clk_in);
    check("newcomer", {8'h00, vector_out}, 16'h0028);
    present(40, 3'h0);
    present(87, 3'h0);
    delay_r = 4'h0;
    quiet();
  endtask

  initial begin
    reset_n_in = 1'b0;
    advanced_mode_in = 1'b0;
    mode2_in = 1'b0;
    mask_bit_in = 1'b0;
    mask_level_in = 3'h0;
    delay_r = 4'h0;
    req_r = 48'h000000000000;
    for (int g = 0; g < 6; g++) begin
      grp_r[g] = 8'h00;
    end
    miscompares = 0;
    n_tests = 0;
    cycles = 0;
    repeat (16) @(negedge ref_clk_in);
    check("reset request", {15'h0000, irq_req_out}, 16'h0000);
    check("reset vector", {8'h00, vector_out}, 16'h0000);
    check("reset address", vector_addr_out, 16'h0000);
    reset_n_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    t_all_vectors();
    t_order();
    t_fields();
    t_mask();
    t_newcomer();
    end_sim();
  end
endmodule // tb

`default_nettype wire
